// ### adcc_analog_model.sv
// Behavioural analog front end: an input level compared against the trial code.
`timescale 1ns/100ps
`default_nettype none
module adcc_analog_model #(
    parameter int LAG_NS = 4
) (
    input wire logic clock_i,
    input wire logic power_i,
    input wire logic [7:0] level_i,
    input wire logic [7:0] trial_i,
    output logic cmp_o
);
    // An unpowered comparator gives nothing useful, so it chatters every cycle.
    logic junk_q = 1'b0;
    wire logic cmp_now;
    always @(posedge clock_i) begin
        junk_q <= !junk_q;
    end
    assign cmp_now = power_i ? (level_i >= trial_i) : junk_q;
    // The lag models a slow settling comparator, well inside the sequencer's wait.
    assign #(LAG_NS) cmp_o = cmp_now;
endmodule // adcc_analog_model
`default_nettype wire

// ### adcc_clk_div.sv
// Conversion clock generator: one tick every 1, 2, 4, 8 or 16 system clocks.
`timescale 1ns/100ps
`include "adcc_map.svh"
`default_nettype none
module adcc_clk_div
    import adcc_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic run_i,
    input wire logic [2:0] div_sel_i,
    output logic tick_o
);

    logic [3:0] cnt_q;
    logic tick_q;
    logic [2:0] sel_clamped;
    logic [3:0] last_count;
    logic wrap;

    // Codes above the largest ratio fall back to the slowest clock, the safe side.
    assign sel_clamped = (div_sel_i > `ADCC_DIV_MAX_SEL) ? `ADCC_DIV_MAX_SEL : div_sel_i;
    assign last_count = 4'((5'h1 << sel_clamped) - 5'h1); // [R06]
    assign wrap = (cnt_q >= last_count);

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !run_i) begin
            cnt_q <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? 4'h0 : cnt_q + 4'h1;
            tick_q <= wrap;
        end
    end

    assign tick_o = tick_q;

endmodule // adcc_clk_div
`default_nettype wire

// ### adcc_conv_ctrl.sv
// Top of the converter control block: registers, start logic, tracking and pin selection.
`timescale 1ns/100ps
`include "adcc_map.svh"
`default_nettype none
module adcc_conv_ctrl
    import adcc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int PINS = 32
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic timer2_ovf_i,
    input wire logic chip_standby_i,
    input wire logic irq_enable_i,
    input wire logic cmp_i,
    output logic [PINS-1:0] analog_pin_o,
    output logic converter_power_o,
    output logic track_o,
    output logic [2:0] gain_o,
    output logic [WIDTH-1:0] dac_code_o,
    output logic conv_irq_o
);

    // -----------------------------------------------------------
    // Registers and state
    // -----------------------------------------------------------
    logic [7:0] analog_input_select_q;
    logic converter_enable_q;
    logic track_mode_select_q;
    logic conversion_done_flag_q;
    logic [1:0] start_mode_field_q;
    logic [2:0] conversion_clock_divider_q;
    logic [2:0] gain_select_field_q;
    logic [WIDTH-1:0] result_data_register_q;
    adcc_state_t state_q;
    logic [1:0] track_cnt_q;
    logic [7:0] rdata_q;
    logic [PINS-1:0] pin_q;
    logic power_q, track_q, irq_q;

    // -----------------------------------------------------------
    // Decode
    // -----------------------------------------------------------
    logic wr_sel, wr_ctl, wr_cfg;
    logic sw_start, hw_start, start_req, start_go;
    logic tick, sar_done, sar_start;
    logic [WIDTH-1:0] sar_result, sar_trial;
    logic busy, timer_mode, track_done;
    logic [7:0] ctl_view, cfg_view, read_mux;
    logic [4:0] pin_index;
    logic track_now;

    assign wr_sel = sfr_wr_i && (sfr_addr_i == `ADCC_ADDR_SEL);
    assign wr_ctl = sfr_wr_i && (sfr_addr_i == `ADCC_ADDR_CTL);
    assign wr_cfg = sfr_wr_i && (sfr_addr_i == `ADCC_ADDR_CFG);

    assign busy = (state_q != ADCC_IDLE); // [R08]
    assign timer_mode = (start_mode_field_q == `ADCC_START_TIMER);
    assign sw_start = wr_ctl && sfr_wdata_i[`ADCC_CTL_BUSY] && !timer_mode; // [R07]
    assign hw_start = timer2_ovf_i && timer_mode; // [R07]
    assign start_req = sw_start || hw_start;
    // A request while busy is dropped rather than queued; software sees no error. [R19]
    assign start_go = start_req && converter_enable_q && !busy; // [R19]
    assign track_done = tick && (track_cnt_q == `ADCC_TRACK_CLKS - 2'h1);
    assign sar_start = (start_go && !track_mode_select_q) || (state_q == ADCC_TRACK && track_done);

    // -----------------------------------------------------------
    // Conversion clock and sequencer
    // -----------------------------------------------------------
    adcc_clk_div u_div (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .run_i(busy),
        .div_sel_i(conversion_clock_divider_q),
        .tick_o(tick)
    );

    adcc_sar #(
        .WIDTH(WIDTH)
    ) u_sar (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .start_i(sar_start),
        .abort_i(!converter_enable_q),
        .tick_i(tick),
        .cmp_i(cmp_i),
        .trial_o(sar_trial),
        .result_o(sar_result),
        .done_o(sar_done)
    );

    // -----------------------------------------------------------
    // Control sequence
    // -----------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_q <= ADCC_IDLE;
            track_cnt_q <= 2'h0;
        end else begin
            case (state_q)
                ADCC_IDLE: begin
                    track_cnt_q <= 2'h0;
                    if (start_go) begin
                        state_q <= track_mode_select_q ? ADCC_TRACK : ADCC_CONVERT; // [R13] [R14]
                    end
                end
                ADCC_TRACK: begin
                    if (!converter_enable_q) begin
                        state_q <= ADCC_IDLE;
                    end else if (track_done) begin // [R13] [R14]
                        state_q <= ADCC_CONVERT;
                    end else if (tick) begin
                        track_cnt_q <= track_cnt_q + 2'h1;
                    end
                end
                ADCC_CONVERT: begin
                    if (!converter_enable_q || sar_done) begin
                        state_q <= ADCC_IDLE; // [R08]
                    end
                end
                default: begin
                    state_q <= ADCC_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------
    // Software registers
    // -----------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            analog_input_select_q <= `ADCC_SEL_RESET;
            {converter_enable_q, track_mode_select_q} <= 2'h0;
            start_mode_field_q <= 2'h0;
            conversion_clock_divider_q <= 3'(`ADCC_CFG_RESET >> `ADCC_CFG_DIV_LO);
            gain_select_field_q <= ADCC_GAIN_1; // [R05]
        end else begin
            if (wr_sel) begin
                analog_input_select_q <= sfr_wdata_i & `ADCC_SEL_MASK;
            end
            if (wr_ctl) begin
                converter_enable_q <= sfr_wdata_i[`ADCC_CTL_EN];
                track_mode_select_q <= sfr_wdata_i[`ADCC_CTL_TRACK_MODE];
                start_mode_field_q <= sfr_wdata_i[`ADCC_CTL_MODE_HI:`ADCC_CTL_MODE_LO];
            end
            if (wr_cfg) begin
                conversion_clock_divider_q <= sfr_wdata_i[`ADCC_CFG_DIV_HI:`ADCC_CFG_DIV_LO];
                gain_select_field_q <= sfr_wdata_i[`ADCC_CFG_GAIN_HI:`ADCC_CFG_GAIN_LO];
            end
        end
    end

    // The done flag is set by completion and cleared only by writing zero; set wins.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            conversion_done_flag_q <= 1'b0;
            result_data_register_q <= `ADCC_DATA_RESET;
        end else begin
            if (sar_done && state_q == ADCC_CONVERT) begin
                conversion_done_flag_q <= 1'b1; // [R09] [R18]
                result_data_register_q <= sar_result; // [R11]
            end else if (wr_ctl && !sfr_wdata_i[`ADCC_CTL_DONE]) begin
                conversion_done_flag_q <= 1'b0; // [R18]
            end
        end
    end

    // -----------------------------------------------------------
    // Read path
    // -----------------------------------------------------------
    assign ctl_view = {converter_enable_q, track_mode_select_q, conversion_done_flag_q, busy,
                       start_mode_field_q, 2'h0};
    assign cfg_view = {conversion_clock_divider_q, 2'h0, gain_select_field_q};
    assign read_mux = (sfr_addr_i == `ADCC_ADDR_SEL) ? analog_input_select_q :
                      (sfr_addr_i == `ADCC_ADDR_CTL) ? ctl_view :
                      (sfr_addr_i == `ADCC_ADDR_CFG) ? cfg_view :
                      (sfr_addr_i == `ADCC_ADDR_DATA) ? 8'(result_data_register_q) : 8'h00;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= sfr_rd_i ? read_mux : 8'h00;
        end
    end

    // -----------------------------------------------------------
    // Analog side outputs
    // -----------------------------------------------------------
    assign pin_index = analog_input_select_q[`ADCC_SEL_PORT_HI:`ADCC_SEL_PIN_LO]; // [R02]
    // Standby shuts the sampler off; continuous tracking otherwise pauses only for conversion.
    assign track_now = converter_enable_q && !chip_standby_i && // [R15]
                       (track_mode_select_q ? (state_q == ADCC_TRACK) // [R13] [R14]
                                            : (state_q != ADCC_CONVERT)); // [R12]

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            always_ff @(posedge clock_i) begin
                if (sys_rst_i) begin
                    pin_q[g] <= 1'b0;
                end else begin
                    pin_q[g] <= analog_input_select_q[`ADCC_SEL_MUX_EN] && (pin_index == 5'(g)); // [R01] [R03]
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            power_q <= 1'b0;
            track_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            power_q <= converter_enable_q; // [R04]
            track_q <= track_now;
            irq_q <= conversion_done_flag_q && irq_enable_i; // [R09]
        end
    end

    logic [2:0] gain_q;
    logic [WIDTH-1:0] dac_q;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            gain_q <= ADCC_GAIN_1;
            dac_q <= '0;
        end else begin
            gain_q <= gain_select_field_q; // [R05]
            dac_q <= (state_q == ADCC_CONVERT) ? sar_trial : '0;
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign analog_pin_o = pin_q;
    assign converter_power_o = power_q;
    assign track_o = track_q;
    assign gain_o = gain_q;
    assign dac_code_o = dac_q;
    assign conv_irq_o = irq_q;

endmodule // adcc_conv_ctrl
`default_nettype wire

// ### adcc_conv_monitor.sv
// Checker bound to the converter control top, watching its ports only.
`timescale 1ns/100ps
`include "adcc_map.svh"
`default_nettype none
module adcc_conv_monitor
    import adcc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int PINS = 32
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic irq_enable_i,
    input wire logic [PINS-1:0] analog_pin_o,
    input wire logic converter_power_o,
    input wire logic [WIDTH-1:0] dac_code_o,
    input wire logic conv_irq_o
);
    // ---------------------------------------------------------------
    // Shadow enables rebuilt from the write strobes
    // ---------------------------------------------------------------
    // Only the enables are shadowed; the sequencer state stays hidden on purpose.
    wire logic sel_wr;
    wire logic ctl_wr;
    logic mux_q;
    logic en_q;
    assign sel_wr = sfr_wr_i && (sfr_addr_i == `ADCC_ADDR_SEL);
    assign ctl_wr = sfr_wr_i && (sfr_addr_i == `ADCC_ADDR_CTL);
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mux_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            mux_q <= sel_wr ? sfr_wdata_i[`ADCC_SEL_MUX_EN] : mux_q;
            en_q <= ctl_wr ? sfr_wdata_i[`ADCC_CTL_EN] : en_q;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    chk_pin_onehot:
        assert property ($onehot0(analog_pin_o)) else $error("more than one analog pin");
    chk_pin_gated:
        assert property (!mux_q && !$past(mux_q) && !$past(mux_q, 2) |-> analog_pin_o == '0)
        else $error("analog pin while mux disabled");
    chk_power_follow:
        assert property (converter_power_o == $past(en_q)) else $error("power does not follow enable");
    chk_dac_idle:
        assert property (!converter_power_o && !$past(converter_power_o) |-> dac_code_o == '0)
        else $error("trial code while powered down");
    chk_dac_first:
        assert property ((dac_code_o != '0) && ($past(dac_code_o) == '0) |-> dac_code_o == {1'b1, {(WIDTH-1){1'b0}}})
        else $error("first trial is not the top bit");
    chk_dac_hold:
        assert property ((dac_code_o != $past(dac_code_o)) && (dac_code_o != '0)
            |=> ($stable(dac_code_o) || dac_code_o == '0) [*5])
        else $error("trial code changed too soon");
    chk_irq_gate:
        assert property (conv_irq_o |-> $past(irq_enable_i)) else $error("interrupt while disabled");
    chk_rdata_idle:
        assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00) else $error("read data without read");
endmodule // adcc_conv_monitor

bind adcc_conv_ctrl adcc_conv_monitor #(.WIDTH(WIDTH), .PINS(PINS)) u_mon (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .irq_enable_i(irq_enable_i),
    .analog_pin_o(analog_pin_o), .converter_power_o(converter_power_o), .dac_code_o(dac_code_o),
    .conv_irq_o(conv_irq_o)
);
`default_nettype wire

// ### adcc_map.svh
// Register map, field positions, reset values and timing counts of the converter control block.
// Contract
// R01: Port pins become analog inputs only while the mux enable bit is set.
// R02: The input select routes exactly the pin named by port and pin fields.
// R03: Other pins of the selected port stay general-purpose I/O.
// R04: Converter, track-and-hold and gain stage run only while converter enable is set.
// R05: Gain field offers 0.5 to 16 and resets to gain one.
// R06: Conversion clock is system clock divided by 1, 2, 4, 8 or 16.
// R07: Start mode selects software busy write or timer two overflow as trigger.
// R08: Busy reads one from conversion start until completion, then hardware clears it.
// R09: Busy falling edge sets the done flag and raises the enabled interrupt; a busy fall caused by clearing converter enable does neither.
// R10: Software polls the done flag, not busy, for on-demand completion.
// R11: A finished conversion places its result in the data register.
// R12: Track mode zero tracks continuously except during a conversion.
// R13: Track mode one with software start tracks three conversion clocks first.
// R14: Track mode one with timer start tracks three conversion clocks first.
// R15: Tracking may be shut down during chip standby or sleep.
// R16: Conversion lasts at least sixteen conversion clocks after tracking ends.
// R17: Software keeps conversion clock under 2.5 MHz and rate under 100 ksps.
// R18: Done flag stays set until software writes zero to it.
// R19: Start requests during tracking or conversion are ignored.
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADCC_ADDR_SEL 8'hBB
`define ADCC_ADDR_CTL 8'hE8
`define ADCC_ADDR_CFG 8'hBC
`define ADCC_ADDR_DATA 8'hBF

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ADCC_SEL_MUX_EN 5
`define ADCC_SEL_PORT_HI 4
`define ADCC_SEL_PORT_LO 3
`define ADCC_SEL_PIN_HI 2
`define ADCC_SEL_PIN_LO 0
`define ADCC_CTL_EN 7
`define ADCC_CTL_TRACK_MODE 6
`define ADCC_CTL_DONE 5
`define ADCC_CTL_BUSY 4
`define ADCC_CTL_MODE_HI 3
`define ADCC_CTL_MODE_LO 2
`define ADCC_CFG_DIV_HI 7
`define ADCC_CFG_DIV_LO 5
`define ADCC_CFG_GAIN_HI 2
`define ADCC_CFG_GAIN_LO 0

// ---------------------------------------------------------------
// Reset values and masks
// ---------------------------------------------------------------
`define ADCC_SEL_RESET 8'h00
`define ADCC_SEL_MASK 8'h3F
`define ADCC_CTL_RESET 8'h00
`define ADCC_CFG_RESET 8'h00
`define ADCC_DATA_RESET 8'h00
`define ADCC_START_TIMER 2'h1

// ---------------------------------------------------------------
// Timing counts in conversion clocks and system clocks
// ---------------------------------------------------------------
`define ADCC_TRACK_CLKS 2'h3
`define ADCC_CMP_SETTLE 3'h5
`define ADCC_DIV_MAX_SEL 3'h4

`endif

// ### adcc_pkg.sv
// Types shared by the converter control block.
`default_nettype none
package adcc_pkg;

    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_TRACK,
        ADCC_CONVERT
    } adcc_state_t;

    // Gain select codes; the reset code selects a gain of one.
    typedef enum logic [2:0] {
        ADCC_GAIN_1 = 3'h0,
        ADCC_GAIN_2 = 3'h1,
        ADCC_GAIN_4 = 3'h2,
        ADCC_GAIN_8 = 3'h3,
        ADCC_GAIN_16 = 3'h4,
        ADCC_GAIN_HALF = 3'h5
    } adcc_gain_t;

endpackage
`default_nettype wire

// ### adcc_sar.sv
// Successive-approximation sequencer: trial code out, synchronised comparator in.
`timescale 1ns/100ps
`include "adcc_map.svh"
`default_nettype none
module adcc_sar
    import adcc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic tick_i,
    input wire logic cmp_i,
    output logic [WIDTH-1:0] trial_o,
    output logic [WIDTH-1:0] result_o,
    output logic done_o
);

    localparam int IDX_W = $clog2(WIDTH);

    logic s1_q, s2_q, s3_q, cmp_q;
    logic active_q, phase_q, done_q;
    logic [IDX_W-1:0] idx_q;
    logic [2:0] settle_q;
    logic [WIDTH-1:0] trial_q;
    logic settled, decide;
    logic [WIDTH-1:0] bit_mask, kept, next_bit;

    // -----------------------------------------------------------
    // Comparator crossing
    // -----------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            cmp_q <= 1'b0;
        end else begin
            s1_q <= cmp_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                cmp_q <= s3_q;
            end
        end
    end

    // -----------------------------------------------------------
    // Bit decisions
    // -----------------------------------------------------------
    // Each bit spends at least two conversion clocks, so eight bits take at least sixteen.
    // The settle wait covers the comparator crossing when the divider is small.
    assign settled = (settle_q == `ADCC_CMP_SETTLE);
    assign decide = active_q && tick_i && phase_q && settled;
    assign bit_mask = WIDTH'(1) << idx_q;
    assign kept = cmp_q ? trial_q : (trial_q & ~bit_mask);
    assign next_bit = bit_mask >> 1;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || abort_i) begin
            active_q <= 1'b0;
            phase_q <= 1'b0;
            idx_q <= '0;
            settle_q <= 3'h0;
            trial_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!settled) begin
                settle_q <= settle_q + 3'h1;
            end
            if (start_i && !active_q) begin
                active_q <= 1'b1;
                phase_q <= 1'b0;
                idx_q <= IDX_W'(WIDTH - 1);
                settle_q <= 3'h0;
                trial_q <= WIDTH'(1) << (WIDTH - 1);
            end else if (active_q && tick_i && !phase_q) begin
                phase_q <= 1'b1;
            end else if (decide) begin // [R16]
                phase_q <= 1'b0;
                settle_q <= 3'h0;
                trial_q <= kept | next_bit;
                idx_q <= idx_q - IDX_W'(1);
                if (idx_q == '0) begin
                    active_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign result_o = trial_q;
    assign trial_o = trial_q;
    assign done_o = done_q;

endmodule // adcc_sar
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/100ps
`include "adcc_map.svh"
`default_nettype none
module tb;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic timer2_ovf_i = 1'b0;
    logic chip_standby_i = 1'b0;
    logic irq_enable_i = 1'b1;
    logic [7:0] analog_level = 8'h00;
    logic cmp_i;
    logic [7:0] sfr_rdata_o;
    logic [31:0] analog_pin_o;
    logic converter_power_o;
    logic track_o;
    logic [2:0] gain_o;
    logic [7:0] dac_code_o;
    logic conv_irq_o;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;

    adcc_conv_ctrl #(.WIDTH(8), .PINS(32)) uut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .timer2_ovf_i(timer2_ovf_i),
        .chip_standby_i(chip_standby_i), .irq_enable_i(irq_enable_i), .cmp_i(cmp_i),
        .analog_pin_o(analog_pin_o), .converter_power_o(converter_power_o), .track_o(track_o),
        .gain_o(gain_o), .dac_code_o(dac_code_o), .conv_irq_o(conv_irq_o)
    );
    adcc_analog_model #(.LAG_NS(4)) u_front (
        .clock_i(clock_i), .power_i(converter_power_o), .level_i(analog_level), .trial_i(dac_code_o), .cmp_o(cmp_i)
    );

    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) cyc++;

    // ---------------------------------------------------------------
    // Bus tasks and comparison
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge clock_i);
        sfr_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge clock_i);
        sfr_rd_i = 1'b0;
        d = sfr_rdata_o;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        rd(a, v);
        check(what, v, exp);
    endtask
    task automatic pulse_timer();
        @(negedge clock_i);
        timer2_ovf_i = 1'b1;
        @(negedge clock_i);
        timer2_ovf_i = 1'b0;
    endtask
    // Completion is learned from the done flag; busy alone can be missed.
    task automatic wait_done();
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 400 && !v[`ADCC_CTL_DONE]; i++) rd(`ADCC_ADDR_CTL, v);
        check("done_seen", v[`ADCC_CTL_DONE], 1'b1);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        #200000;
        mismatches++;
        close_out();
    end

    initial begin
        int t0;
        int cnt;
        repeat (10) @(negedge clock_i);
        sys_rst_i = 1'b0;
        rd_chk(`ADCC_ADDR_SEL, 8'h00, "sel_reset");
        rd_chk(`ADCC_ADDR_CTL, 8'h00, "ctl_reset");
        rd_chk(`ADCC_ADDR_CFG, 8'h00, "cfg_reset");
        rd_chk(8'hBD, 8'h00, "unmapped");
        check("gain_reset", gain_o, adcc_pkg::ADCC_GAIN_1);
        $display("test reset done");
        wr(`ADCC_ADDR_SEL, 8'hFC);
        rd_chk(`ADCC_ADDR_SEL, 8'h3C, "sel_mask");
        for (int p = 0; p < 4; p++) begin
            wr(`ADCC_ADDR_SEL, 8'(8'h20 | (p << 3) | (7 - p)));
            repeat (2) @(negedge clock_i);
            check("pin_select", analog_pin_o, 32'h1 << (p * 8 + 7 - p));
        end
        wr(`ADCC_ADDR_SEL, 8'h1C);
        repeat (3) @(negedge clock_i);
        check("pin_mux_off", analog_pin_o, 32'h0);
        for (int g = 0; g < 6; g++) begin
            wr(`ADCC_ADDR_CFG, 8'(g));
            repeat (2) @(negedge clock_i);
            check("gain", gain_o, g);
        end
        $display("test select and gain done");
        wr(`ADCC_ADDR_CTL, 8'h80);
        repeat (2) @(negedge clock_i);
        check("power_on", converter_power_o, 1'b1);
        check("track_idle", track_o, 1'b1);
        // At this clock every divider breaks the analog rate limit; the model ignores it.
        for (int k = 0; k < 5; k++) begin
            analog_level = 8'(8'h35 + k * 8'h31);
            wr(`ADCC_ADDR_CFG, 8'(k << 5));
            t0 = cyc;
            wr(`ADCC_ADDR_CTL, 8'hB0);
            rd_chk(`ADCC_ADDR_CTL, (k == 0) ? 8'h90 : 8'hB0, "busy_keeps_done");
            check("track_stops", track_o, 1'b0);
            pulse_timer();
            wr(`ADCC_ADDR_CTL, 8'hB0);
            wr(`ADCC_ADDR_CTL, 8'h80);
            wait_done();
            check("conv_length", (cyc - t0) >= 16 * (1 << k), 1'b1);
            rd_chk(`ADCC_ADDR_DATA, analog_level, "result");
            rd_chk(`ADCC_ADDR_CTL, 8'hA0, "busy_clear");
            check("irq", conv_irq_o, 1'b1);
            repeat (20) @(negedge clock_i);
            check("no_restart", dac_code_o, 8'h00);
        end
        irq_enable_i = 1'b0;
        chip_standby_i = 1'b1;
        repeat (2) @(negedge clock_i);
        check("irq_masked", conv_irq_o, 1'b0);
        check("standby_track", track_o, 1'b0);
        irq_enable_i = 1'b1;
        chip_standby_i = 1'b0;
        $display("test software start done");
        wr(`ADCC_ADDR_CFG, 8'h00);
        for (int m = 0; m < 2; m++) begin
            wr(`ADCC_ADDR_CTL, m ? 8'hC4 : 8'hC0);
            if (m) wr(`ADCC_ADDR_CTL, 8'hD4);
            else pulse_timer();
            repeat (10) @(negedge clock_i);
            check("wrong_trigger", {track_o, dac_code_o}, 9'h000);
            if (m) pulse_timer();
            else wr(`ADCC_ADDR_CTL, 8'hD0);
            cnt = 0;
            for (int i = 0; i < 50 && dac_code_o === 8'h00; i++) begin
                @(negedge clock_i);
                cnt += int'(track_o);
            end
            check("track_len", cnt >= 2 && cnt <= 5, 1'b1);
            wait_done();
            rd_chk(`ADCC_ADDR_DATA, analog_level, "result_tracked");
        end
        $display("test track mode done");
        wr(`ADCC_ADDR_CTL, 8'h80);
        wr(`ADCC_ADDR_CTL, 8'h90);
        wr(`ADCC_ADDR_CTL, 8'h00);
        repeat (3) @(negedge clock_i);
        check("abort_power", {converter_power_o, dac_code_o}, 9'h000);
        rd_chk(`ADCC_ADDR_CTL, 8'h00, "abort_no_done");
        $display("test abort done");
        close_out();
    end
endmodule // tb
`default_nettype wire
